/* common/sac_defs.svh */
// Operation
// R1: prescaler counts while converter_enable is set, held in reset while it is low.
// R2: prescaler divides the CPU clock; software keeps converter clock in 50-200 kHz.
// R3: a software start begins its conversion on the next converter clock rising edge.
// R4: normal conversions last 13 converter cycles, the first after enable 25.
// R5: sample-and-hold at 1.5 cycles normally, 13.5 cycles in the first conversion.
// R6: at the end, store result, set complete flag, clear start bit in single mode.
// R7: auto trigger resets prescaler, samples 2 cycles later, lasts 13.5 cycles.
// R8: differential auto-triggered from a non-complete source always runs extended, 25 cycles.
// R9: free-running restarts at once on completion and keeps the start bit set.
// R10: differential conversions align sample-and-hold to a half-rate converter clock phase.
// R11: software differential start takes 13 cycles with half clock low, 14 when high.
// R12: automatic free-running differential restarts take 14 cycles each.
// R13: software toggles enable between auto-triggered differential gain conversions.
// R14: selections buffered and copied continuously, locked once a conversion starts.
// R15: copying resumes in the last converter cycle before the complete flag sets.
// R16: software waits one converter cycle after a start before changing selections.
// R17: under auto trigger, software changes selections only at the three safe moments.
// R18: software waits 125 us after differential channel or reference change.
// R19: a free-running channel change after completion only affects later conversions.
// R20: selected trigger rising edge resets prescaler and starts; edges while busy ignored.
// R21: start bit reads one while any conversion is in progress.
// R22: prescale selection picks power-of-two ratios, taken only between conversions.
// R23: a half-cycle counter places sample-and-hold and completion for each conversion kind.
`ifndef SAC_DEFS_SVH
`define SAC_DEFS_SVH
`define SAC_OFS_CTRL 8'h00
`define SAC_OFS_SEL 8'h04
`define SAC_OFS_TRIG 8'h08
`define SAC_OFS_RES 8'h0C
`define SAC_OFS_STAT 8'h10
`define SAC_B_EN 0
`define SAC_B_START 1
`define SAC_B_AUTO 2
`define SAC_B_FLAG 3
`define SAC_B_PS 4
`define SAC_B_CH 0
`define SAC_B_REF 6
`define SAC_B_SRC 0
`define SAC_RST_PS 3'h0
`define SAC_RST_SRC 3'h0
`define SAC_SRC_FREE 3'h0
`define SAC_H_SAMP_NORM 6'h03
`define SAC_H_DONE_NORM 6'h1A
`define SAC_H_SAMP_EXT 6'h1B
`define SAC_H_DONE_EXT 6'h32
`define SAC_H_SAMP_TRIG 6'h04
`define SAC_H_DONE_TRIG 6'h1B
`define SAC_H_SAMP_DIFF 6'h05
`define SAC_H_DONE_DIFF 6'h1C
`define SAC_REF_CLK_KHZ 40000
`define SAC_FCONV_MIN_KHZ 50
`define SAC_FCONV_MAX_KHZ 200
`define SAC_FCPU_MIN_KHZ 100
`define SAC_DIV_MIN ((`SAC_REF_CLK_KHZ + `SAC_FCONV_MAX_KHZ - 1) / `SAC_FCONV_MAX_KHZ)
`define SAC_DIV_MAX (`SAC_REF_CLK_KHZ / `SAC_FCONV_MIN_KHZ)
`endif

/* common/sac_pkg.sv */
package sac_pkg;
  typedef struct packed {
    logic [1:0] ref_sel;
    logic [4:0] chan;
  } sac_sel_s;
  typedef struct packed {
    logic [5:0] samp;
    logic [5:0] done;
  } sac_tim_s;
  typedef enum logic [1:0] {
    KIND_NORM,
    KIND_EXT,
    KIND_TRIG,
    KIND_DIFF
  } sac_kind_e;
endpackage : sac_pkg

/* src/sac_prescaler.sv */
`timescale 1ns/100ps
`default_nettype none
`include "sac_defs.svh"
module sac_prescaler #(
  parameter int PS_W = 3,
  parameter int CNT_W = 8
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic clr_i,
  input wire logic [PS_W-1:0] sel_i,
  output logic rise_o,
  output logic fall_o
);
  generate
    if (CNT_W < (1 << PS_W) || (1 << CNT_W) < `SAC_DIV_MIN) begin : g_bad
      $error("sac_prescaler: counter too narrow for the prescale field");
    end
  endgenerate
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  wire [CNT_W:0] span = {{CNT_W{1'b0}}, 1'b1} << ({1'b0, sel_i} + 1'b1); // R2
  wire [CNT_W:0] span_m1 = span - {{CNT_W{1'b0}}, 1'b1};
  wire [CNT_W-1:0] mask = span_m1[CNT_W-1:0];
  // power-of-two ratio 2^(sel+1), cleared while held
  // a count left above a newly smaller ratio wraps at once instead of running to full scale
  assign rise_o = !clr_i && (cnt_q >= mask); // R22
  assign fall_o = !clr_i && (cnt_q == (mask >> 1));
  assign cnt_d = (clr_i || rise_o) ? '0 : cnt_q + 1'b1; // R1
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule : sac_prescaler
`default_nettype wire

/* src/sac_trig_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module sac_trig_sync (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic trig_i,
  output logic edge_o
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  // three cpu cycles from the trigger rising edge to the pulse
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      edge_o <= 1'b0;
    end else begin
      s1_q <= trig_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      edge_o <= s2_q & ~s3_q; // R7
    end
  end
endmodule : sac_trig_sync
`default_nettype wire

/* src/sac_sequencer.sv */
// Decided for this implementation: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "sac_defs.svh"
module sac_sequencer #(
  parameter int PS_W = 3,
  parameter int CNT_W = 8,
  parameter int RES_W = 10
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic [6:0] trig_src_i,
  input wire logic [RES_W-1:0] result_i,
  output logic sample_hold_o,
  output logic conv_start_o,
  output logic conv_done_o,
  output logic busy_o,
  output sac_pkg::sac_sel_s active_sel_o
);
  generate
    if (PS_W != 3 || RES_W > 16) begin : g_bad
      $error("sac_sequencer: unsupported field widths");
    end
  endgenerate

  // bus address phase capture
  logic wr_q;
  logic [7:0] addr_q;
  logic [31:0] hrdata_q;
  logic hreadyout_q;
  logic hresp_q;
  // software state
  logic en_q;
  logic auto_q;
  logic [PS_W-1:0] ps_q;
  logic [PS_W-1:0] ps_act_q;
  logic [2:0] src_q;
  sac_pkg::sac_sel_s tmp_q;
  sac_pkg::sac_sel_s act_q;
  logic flag_q;
  logic [RES_W-1:0] result_q;
  // conversion state
  logic pend_q;
  logic busy_q;
  logic first_q;
  logic lock_q;
  logic half_q;
  logic [5:0] hcnt_q;
  sac_pkg::sac_tim_s tim_q;
  logic sh_q;
  logic cst_q;
  logic cdone_q;

  wire accept = hsel_i && hready_i && htrans_i[1];
  wire [7:0] haddr_lo = haddr_i[7:0];
  wire in_range = (haddr_i[31:8] == 24'h000000);
  wire wr_ctrl = wr_q && (addr_q == `SAC_OFS_CTRL);
  wire wr_sel = wr_q && (addr_q == `SAC_OFS_SEL);
  wire wr_trig = wr_q && (addr_q == `SAC_OFS_TRIG);
  wire w_en = hwdata_i[`SAC_B_EN];
  wire w_start = hwdata_i[`SAC_B_START];
  wire w_auto = hwdata_i[`SAC_B_AUTO];
  wire w_flag = hwdata_i[`SAC_B_FLAG];
  wire [PS_W-1:0] w_ps = hwdata_i[`SAC_B_PS +: PS_W];
  wire [4:0] w_chan = hwdata_i[`SAC_B_CH +: 5];
  wire [1:0] w_ref = hwdata_i[`SAC_B_REF +: 2];
  wire [2:0] w_src = hwdata_i[`SAC_B_SRC +: 3];

  // prescaler ticks and trigger edge
  logic rise_tick;
  logic fall_tick;
  logic trig_ev;
  wire [7:0] trig_vec = {trig_src_i, 1'b0};
  wire trig_sel = trig_vec[src_q];
  wire src_free = (src_q == `SAC_SRC_FREE);
  wire half_tick = rise_tick || fall_tick;
  wire [5:0] hcnt_inc = hcnt_q + 6'h01;
  wire done_ev = busy_q && half_tick && (hcnt_inc == tim_q.done); // R23
  wire samp_ev = busy_q && half_tick && (hcnt_inc == tim_q.samp); // R23
  wire last_cyc = busy_q && half_tick && (hcnt_inc == (tim_q.done - 6'h02)); // R15
  wire diff_now = (tmp_q.chan[4:3] != 2'h0);
  wire trig_start = en_q && auto_q && !src_free && trig_ev && !busy_q; // R20
  wire sw_start = en_q && pend_q && rise_tick && !busy_q && !trig_start; // R3
  wire fr_start = en_q && auto_q && src_free && done_ev; // R9
  wire start_ev = trig_start || sw_start || fr_start;
  wire ext = first_q || (diff_now && auto_q && !src_free); // R8
  wire presc_clr = !en_q || trig_start; // R1 R7
  wire start_rd = pend_q || busy_q; // R21

  sac_pkg::sac_kind_e kind;
  sac_pkg::sac_tim_s tim_new;

  // differential starts that are neither extended nor triggered and find the half clock high, and all automatic
  // free-running differential restarts, are pushed one converter cycle
  always_comb begin
    if (ext) begin
      kind = sac_pkg::KIND_EXT; // R4
    end else if (trig_start) begin
      kind = sac_pkg::KIND_TRIG; // R7
    end else if (diff_now && (half_q || fr_start)) begin
      kind = sac_pkg::KIND_DIFF; // R11 R12
    end else begin
      kind = sac_pkg::KIND_NORM;
    end
  end

  always_comb begin
    unique case (kind)
      sac_pkg::KIND_EXT: begin
        tim_new = '{samp: `SAC_H_SAMP_EXT, done: `SAC_H_DONE_EXT}; // R5
      end
      sac_pkg::KIND_TRIG: begin
        tim_new = '{samp: `SAC_H_SAMP_TRIG, done: `SAC_H_DONE_TRIG};
      end
      sac_pkg::KIND_DIFF: begin
        tim_new = '{samp: `SAC_H_SAMP_DIFF, done: `SAC_H_DONE_DIFF}; // R10
      end
      sac_pkg::KIND_NORM: begin
        tim_new = '{samp: `SAC_H_SAMP_NORM, done: `SAC_H_DONE_NORM}; // R5
      end
    endcase
  end

  // next values
  wire en_d = wr_ctrl ? w_en : en_q;
  wire en_rise = wr_ctrl && w_en && !en_q;
  wire pend_set = wr_ctrl && w_en && w_start;
  wire pend_d = !en_d ? 1'b0 : pend_set ? 1'b1 : start_ev ? 1'b0 : pend_q;
  wire busy_d = !en_d ? 1'b0 : start_ev ? 1'b1 : done_ev ? 1'b0 : busy_q; // R6 R9
  wire first_d = en_rise ? 1'b1 : start_ev ? 1'b0 : first_q;
  wire lock_d = !en_d ? 1'b0 : start_ev ? 1'b1 : last_cyc ? 1'b0 : lock_q; // R14 R15
  wire flag_d = done_ev ? 1'b1 : (wr_ctrl && w_flag) ? 1'b0 : flag_q; // R6
  wire half_d = !en_q ? 1'b0 : rise_tick ? !half_q : half_q; // R10
  wire [5:0] hcnt_d = start_ev ? 6'h00 : (busy_q && half_tick) ? hcnt_inc : hcnt_q;
  wire [PS_W-1:0] ps_act_d = busy_q ? ps_act_q : ps_q; // R22
  sac_pkg::sac_sel_s act_d;
  assign act_d = (start_ev || !lock_q) ? tmp_q : act_q; // R14 R19

  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h00000000;
    if (in_range) begin
      unique case (haddr_lo)
        `SAC_OFS_CTRL: rd_word = {25'h0000000, ps_q, flag_q, auto_q, start_rd, en_q};
        `SAC_OFS_SEL: rd_word = {24'h000000, tmp_q.ref_sel, 1'b0, tmp_q.chan};
        `SAC_OFS_TRIG: rd_word = {29'h00000000, src_q};
        `SAC_OFS_RES: rd_word = {{(32 - RES_W){1'b0}}, result_q};
        `SAC_OFS_STAT: rd_word = {27'h0000000, lock_q, half_q, first_q, pend_q, busy_q};
        default: rd_word = 32'h00000000;
      endcase
    end
  end

  sac_prescaler #(
    .PS_W(PS_W),
    .CNT_W(CNT_W)
  ) u_presc (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .clr_i(presc_clr),
    .sel_i(ps_act_q),
    .rise_o(rise_tick),
    .fall_o(fall_tick)
  );

  sac_trig_sync u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .trig_i(trig_sel),
    .edge_o(trig_ev)
  );

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      wr_q <= 1'b0;
      addr_q <= 8'h00;
      hrdata_q <= 32'h00000000;
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end else begin
      wr_q <= accept && hwrite_i && in_range;
      addr_q <= haddr_lo;
      hrdata_q <= (accept && !hwrite_i) ? rd_word : hrdata_q;
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      en_q <= 1'b0;
      auto_q <= 1'b0;
      ps_q <= `SAC_RST_PS;
      src_q <= `SAC_RST_SRC;
      tmp_q <= '0;
    end else begin
      en_q <= en_d;
      auto_q <= wr_ctrl ? w_auto : auto_q;
      ps_q <= wr_ctrl ? w_ps : ps_q;
      src_q <= wr_trig ? w_src : src_q;
      tmp_q <= wr_sel ? sac_pkg::sac_sel_s'{ref_sel: w_ref, chan: w_chan} : tmp_q;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      pend_q <= 1'b0;
      busy_q <= 1'b0;
      first_q <= 1'b0;
      lock_q <= 1'b0;
      flag_q <= 1'b0;
      half_q <= 1'b0;
      hcnt_q <= 6'h00;
      tim_q <= '0;
      ps_act_q <= `SAC_RST_PS;
      act_q <= '0;
    end else begin
      pend_q <= pend_d;
      busy_q <= busy_d;
      first_q <= first_d;
      lock_q <= lock_d;
      flag_q <= flag_d;
      half_q <= half_d;
      hcnt_q <= hcnt_d;
      tim_q <= start_ev ? tim_new : tim_q; // R23
      ps_act_q <= ps_act_d;
      act_q <= act_d;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      result_q <= '0;
      sh_q <= 1'b0;
      cst_q <= 1'b0;
      cdone_q <= 1'b0;
    end else begin
      result_q <= done_ev ? result_i : result_q; // R6
      sh_q <= samp_ev;
      cst_q <= start_ev;
      cdone_q <= done_ev;
    end
  end

  assign hrdata_o = hrdata_q;
  assign hreadyout_o = hreadyout_q;
  assign hresp_o = hresp_q;
  assign sample_hold_o = sh_q;
  assign conv_start_o = cst_q;
  assign conv_done_o = cdone_q;
  assign busy_o = busy_q;
  assign active_sel_o = act_q;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_presc_held_off: assert property (!en_q |-> !rise_tick && !fall_tick) // R1
    else $error("prescaler ticked while disabled");
  a_sw_start_tick: assert property (sw_start |=> busy_q && hcnt_q == 6'h00) // R3
    else $error("software start did not begin on converter edge");
  a_first_timing: assert property (start_ev && first_q |=> tim_q.done == 6'h32 && tim_q.samp == 6'h1B) // R4
    else $error("first conversion not extended");
  a_norm_timing: assert property (start_ev && !ext && !trig_start && !diff_now
      |=> tim_q.done == 6'h1A && tim_q.samp == 6'h03) // R5
    else $error("normal conversion timing wrong");
  a_done_flag: assert property (done_ev |=> flag_q && result_q == $past(result_i)) // R6
    else $error("completion did not store result and set flag");
  a_single_clear: assert property (done_ev && !auto_q && !pend_q && !pend_set |=> !start_rd) // R6
    else $error("start bit not cleared in single mode");
  a_trig_timing: assert property (trig_start && !ext |=> tim_q.samp == 6'h04 && tim_q.done == 6'h1B
      && !rise_tick) // R7
    else $error("triggered conversion timing wrong");
  a_diff_ext: assert property (start_ev && diff_now && auto_q && !src_free |=> tim_q.done == 6'h32) // R8
    else $error("differential triggered conversion not extended");
  a_free_run: assert property (done_ev && en_q && auto_q && src_free && en_d |=> busy_q && start_rd) // R9
    else $error("free running did not restart");
  a_half_rate: assert property (en_q && rise_tick |=> half_q != $past(half_q)) // R10
    else $error("half rate clock did not toggle");
  a_diff_high: assert property (sw_start && diff_now && !ext && half_q |=> tim_q.done == 6'h1C) // R11
    else $error("differential start with half clock high not 14 cycles");
  a_diff_restart: assert property (fr_start && diff_now && !ext |=> tim_q.done == 6'h1C) // R12
    else $error("free running differential restart not 14 cycles");
  a_sel_locked: assert property (lock_q && !start_ev |=> act_q == $past(act_q)) // R14
    else $error("active selection changed while locked");
  a_unlock_last: assert property (last_cyc && !start_ev |=> !lock_q) // R15
    else $error("selection not released in last cycle");
  a_trig_ignored: assert property (busy_q |-> !trig_start) // R20
    else $error("trigger accepted during conversion");
  a_start_reads: assert property (busy_q |-> start_rd) // R21
    else $error("start bit low during conversion");
  a_ps_stable: assert property (busy_q |=> ps_act_q == $past(ps_act_q)) // R22
    else $error("prescale ratio changed mid conversion");
endmodule : sac_sequencer
`default_nettype wire

/* bench/sac_core_model.sv */
`timescale 1ns/100ps
`default_nettype none
module sac_core_model (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic sample_hold_i,
  input wire logic conv_done_i,
  input wire logic [6:0] trig_req_i,
  output logic [6:0] trig_src_o,
  output var logic [9:0] result_o,
  output var logic [9:0] held_o
);
  logic hold_q = 1'b0;
  initial result_o = 10'h000;
  initial held_o = 10'h155;
  // trigger lines are plain levels; the sequencer looks for their rising edges
  assign trig_src_o = trig_req_i;
  // result is valid only from sample-and-hold to completion, otherwise it toggles
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      hold_q <= 1'b0;
      held_o <= 10'h155;
      result_o <= 10'h000;
    end else if (sample_hold_i) begin
      hold_q <= 1'b1;
      held_o <= held_o + 10'h0CB;
      result_o <= held_o + 10'h0CB;
    end else begin
      if (conv_done_i) begin
        hold_q <= 1'b0;
      end
      result_o <= hold_q ? held_o : ~result_o;
    end
  end
endmodule : sac_core_model
`default_nettype wire

/* bench/sac_sequencer_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "sac_defs.svh"
module sac_sequencer_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hready, hresp, sh, cst, cdn, busy;
  logic [6:0] trig_req = 7'h00;
  logic [6:0] trig_src;
  logic [9:0] res, held;
  sac_pkg::sac_sel_s act;
  logic [31:0] q, s0, cyc = 0, t_st = 0, t_sh = 0, d_sh = 0, d_dn = 0, n_st = 0, n_dn = 0;
  int err_count = 0;
  int samples_checked = 0;
  // control word with start and flag clear, sample and done spacing in cpu cycles
  logic [31:0] rows [0:2][0:2] = '{'{32'h0B, 32'd3, 32'd26}, '{32'h1B, 32'd6, 32'd52},
    '{32'h2B, 32'd12, 32'd104}};

  always #12.5 clk = ~clk;

  sac_sequencer DUT (.ref_clk_i(clk), .rst_n_i(rst_n), .hsel_i(1'b1), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .trig_src_i(trig_src),
    .result_i(res), .sample_hold_o(sh), .conv_start_o(cst), .conv_done_o(cdn), .busy_o(busy),
    .active_sel_o(act));
  sac_core_model core (.ref_clk_i(clk), .rst_n_i(rst_n), .sample_hold_i(sh),
    .conv_done_i(cdn), .trig_req_i(trig_req), .trig_src_o(trig_src), .result_o(res),
    .held_o(held));

  // pulse timestamps; spacing is latched at completion before a restart can overwrite it
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cst === 1'b1) begin
      t_st <= cyc;
      n_st <= n_st + 1;
    end
    if (sh === 1'b1) begin
      t_sh <= cyc;
    end
    if (cdn === 1'b1) begin
      d_sh <= t_sh - t_st;
      d_dn <= cyc - t_st;
      n_dn <= n_dn + 1;
    end
  end

  task automatic conclude();
    if (err_count == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
    bus(1'b0, a, 32'h0);
    chk(name, q, exp);
  endtask : rd

  // waits for the next completion (done) or start pulse
  task automatic wt(input logic done);
    logic [31:0] k;
    k = done ? n_dn : n_st;
    for (int i = 0; i < 3000 && (done ? n_dn : n_st) == k; i++) @(posedge clk);
    if ((done ? n_dn : n_st) == k) begin
      chk("event wait", 32'h0, 32'h1);
    end
  endtask : wt

  task automatic meas(input logic [31:0] s, input logic [31:0] d);
    wt(1'b1);
    chk("sample spacing", d_sh, s);
    chk("done spacing", d_dn, d);
  endtask : meas

  // cut a hang at roughly sixty times the expected run length
  initial begin
    #1000000;
    err_count++;
    conclude();
  end

  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("hreadyout", 32'(hready), 32'h1);
    chk("hresp", 32'(hresp), 32'h0);
    wr(8'h14, 32'hFFFFFFFF);
    for (int i = 0; i < 6; i++) rd(8'(i * 4), 32'h0, "reset value");
    // converter clock is 20 MHz here for run time; real software keeps 50-200 kHz
    wr(`SAC_OFS_SEL, 32'h41);
    wr(`SAC_OFS_CTRL, 32'h03);
    meas(27, 50);
    rd(`SAC_OFS_CTRL, 32'h09, "ctrl after single");
    rd(`SAC_OFS_RES, {22'h0, held}, "result");
    chk("active sel idle", 32'(act), 32'h21);
    for (int i = 0; i < 3; i++) begin
      wr(`SAC_OFS_CTRL, rows[i][0]);
      meas(rows[i][1], rows[i][2]);
      rd(`SAC_OFS_CTRL, (rows[i][0] & 32'h71) | 32'h08, "ctrl row");
    end
    wr(`SAC_OFS_CTRL, 32'h0B);
    wt(1'b0);
    wr(`SAC_OFS_SEL, 32'h85);
    wr(`SAC_OFS_CTRL, 32'h21);
    chk("locked sel", 32'(act), 32'h21);
    rd(`SAC_OFS_CTRL, 32'h23, "start while busy");
    meas(3, 26);
    chk("released sel", 32'(act), 32'h45);
    // differential results inside the gain settling time are discarded, never compared
    wr(`SAC_OFS_SEL, 32'h08);
    wr(`SAC_OFS_CTRL, 32'h0F);
    wt(1'b1);
    chk("diff start", 32'((d_dn === 26 && d_sh === 3) || (d_dn === 28 && d_sh === 5)), 1);
    wr(`SAC_OFS_SEL, 32'h10);
    chk("frozen sel", 32'(act), 32'h08);
    rd(`SAC_OFS_CTRL, 32'h0F, "free running ctrl");
    meas(5, 28);
    chk("next sel", 32'(act), 32'h10);
    wr(`SAC_OFS_CTRL, 32'h09);
    wt(1'b1);
    rd(`SAC_OFS_CTRL, 32'h09, "free running stop");
    wr(`SAC_OFS_SEL, 32'h02);
    wr(`SAC_OFS_TRIG, 32'h01);
    wr(`SAC_OFS_CTRL, 32'h0D);
    s0 = n_st;
    trig_req <= 7'h01;
    repeat (12) @(posedge clk);
    trig_req <= 7'h00;
    repeat (2) @(posedge clk);
    trig_req <= 7'h01;
    rd(`SAC_OFS_CTRL, 32'h07, "triggered busy");
    meas(4, 27);
    repeat (40) @(posedge clk);
    chk("starts per trigger", n_st, s0 + 1);
    trig_req <= 7'h00;
    wr(`SAC_OFS_CTRL, 32'h0C);
    wr(`SAC_OFS_SEL, 32'h08);
    wr(`SAC_OFS_CTRL, 32'h05);
    for (int i = 0; i < 2; i++) begin
      trig_req <= 7'h01;
      meas(27, 50);
      trig_req <= 7'h00;
      wr(`SAC_OFS_CTRL, 32'h0D);
    end
    wr(`SAC_OFS_CTRL, 32'h0B);
    wt(1'b0);
    wr(`SAC_OFS_CTRL, 32'h00);
    repeat (2) @(posedge clk);
    chk("abort busy", 32'(busy), 32'h0);
    rd(`SAC_OFS_CTRL, 32'h0, "abort ctrl");
    conclude();
  end
endmodule : sac_sequencer_tb
`default_nettype wire
